// [rtl/servo_mode_and_torque_limit_select.sv]
// control mode, preset speed and torque limit selection of one axis
// assumes host strobes on clk_in, combo strap valid at reset
`timescale 1ns/100ps
module servo_mode_and_torque_limit_select #(
    parameter int PRESET_FILTER = mode_pkg::PRESET_FILTER_CYCLES,
    parameter int MS_TICK       = mode_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    // register port
    input  wire mode_pkg::reg_req_t          reg_req_in,
    output logic      [mode_pkg::DATA_W-1:0] rd_data_out,
    // configuration strap and host pins
    input  wire logic [mode_pkg::CODE_W-1:0] control_combo_code_in,
    input  wire mode_pkg::host_inputs_t      host_n_in,
    // position sources
    input  wire logic                        contact_positioning_in,
    input  wire logic [mode_pkg::POS_W-1:0]  commanded_pos_in,
    input  wire logic [mode_pkg::POS_W-1:0]  contact_target_in,
    // mode results
    output mode_pkg::mode_sel_t              mode_sel_out,
    output logic      [mode_pkg::SPD_W-1:0]  preset_speed_out,
    output logic                             decel_active_out,
    output logic                             combo_error_out,
    // torque limits
    output logic      [mode_pkg::TQ_W-1:0]   fwd_torque_limit_out,
    output logic      [mode_pkg::TQ_W-1:0]   rev_torque_limit_out,
    // monitor
    output logic      [mode_pkg::POS_W-1:0]  target_position_monitor_out
);
    import mode_pkg::*;

    localparam int FCNT_W = $clog2(PRESET_FILTER + 1);
    localparam int TICK_W = $clog2(MS_TICK + 1);

    // synchronised inputs
    logic [3:0]   sync_bits;
    host_inputs_t host_s;

    input_sync #(
        .W(4)
    ) u_sync (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .raw_n_in(host_n_in),
        .sync_out(sync_bits)
    );

    assign host_s = host_inputs_t'(sync_bits);

    // combination code, caught once after reset release
    logic              started_q;
    logic [CODE_W-1:0] code_q;
    wire               code_legal;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            started_q <= 1'b0;
            code_q    <= CODE_RST;
        end else if (!started_q) begin
            started_q <= 1'b1;
            code_q    <= control_combo_code_in;
        end
    end

    assign code_legal = started_q &&
                        (code_q >= CODE_PSPD_ASPD) &&
                        (code_q <= CODE_POS_INH);

    // preset select filter: the inputs must differ from the held level for a full window
    wire  [1:0]        sel_raw;
    logic [1:0]        sel_q;
    logic [FCNT_W-1:0] fcnt_q;
    wire               sel_same;
    wire               fcnt_done;

    assign sel_raw   = {host_s.preset_select_a, host_s.reverse_ext_limit};
    assign sel_same  = (sel_raw == sel_q);
    assign fcnt_done = (fcnt_q == FCNT_W'(PRESET_FILTER - 1));

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_q  <= 2'h0;
            fcnt_q <= '0;
        end else if (sel_same) begin
            fcnt_q <= '0;
        end else if (fcnt_done) begin
            sel_q  <= sel_raw;
            fcnt_q <= '0;
        end else begin
            fcnt_q <= fcnt_q + FCNT_W'(1);
        end
    end

    // mode decode
    function automatic mode_sel_t decode(
        input logic [CODE_W-1:0] code,
        input logic              legal,
        input logic              msw,
        input logic [1:0]        sel
    );
        mode_sel_t m;
        logic      preset_on;
        m         = '0;
        m.mode    = MODE_NONE;
        preset_on = msw || (sel != 2'h0);
        if (legal) begin
            unique case (code)
                CODE_PSPD_ASPD,
                CODE_PSPD_POS,
                CODE_PSPD_TRQ: begin
                    if (preset_on) begin
                        m.mode    = MODE_PRESET;
                        m.reverse = msw;
                        m.preset  = {msw, sel};
                    end else if (code == CODE_PSPD_ASPD) begin
                        m.mode = MODE_SPEED;
                    end else if (code == CODE_PSPD_POS) begin
                        m.mode = MODE_POSITION;
                    end else begin
                        m.mode = MODE_TORQUE;
                    end
                end
                CODE_POS_ASPD: begin
                    m.mode = msw ? MODE_SPEED : MODE_POSITION;
                end
                CODE_POS_TRQ: begin
                    m.mode = msw ? MODE_TORQUE : MODE_POSITION;
                end
                CODE_TRQ_ASPD: begin
                    m.mode = msw ? MODE_SPEED : MODE_TORQUE;
                end
                CODE_ASPD_ZCL: begin
                    m.mode       = MODE_SPEED;
                    m.zero_clamp = msw;
                end
                CODE_POS_INH: begin
                    m.mode          = MODE_POSITION;
                    m.pulse_inhibit = msw;
                end
                default: begin
                    m.mode = MODE_NONE;
                end
            endcase
        end
        return m;
    endfunction

    mode_sel_t want;
    assign want = decode(code_q, code_legal, host_s.mode_switch, sel_q);

    // deceleration hold between preset speed and pulse position
    decel_state_t      state_q;
    decel_state_t      state_d;
    mode_sel_t         applied_q;
    mode_sel_t         applied_d;
    logic [TICK_W-1:0] tick_q;
    logic [SPD_W-1:0]  ms_q;
    logic [SPD_W-1:0]  jog_decel_q;
    wire               enter_decel;
    wire               decel_done;
    wire               leave_decel;
    wire               tick_wrap;

    assign enter_decel = (state_q == ST_RUN) &&
                         (applied_q.mode == MODE_PRESET) &&
                         (want.mode == MODE_POSITION);
    assign decel_done  = (ms_q >= jog_decel_q);
    assign leave_decel = (state_q == ST_DECEL) &&
                         ((want.mode != MODE_POSITION) || decel_done);
    assign tick_wrap   = (tick_q == TICK_W'(MS_TICK - 1));

    assign state_d = (state_q == ST_RUN) ?
                     (enter_decel ? ST_DECEL : ST_RUN) :
                     (leave_decel ? ST_RUN : ST_DECEL);
    // position control is held off until the stop time has run out
    assign applied_d = ((state_d == ST_RUN) || leave_decel) ?
                       want : applied_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= ST_RUN;
            applied_q <= '0;
        end else begin
            state_q   <= state_d;
            applied_q <= applied_d;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_q <= '0;
            ms_q   <= '0;
        end else if (state_q != ST_DECEL) begin
            tick_q <= '0;
            ms_q   <= '0;
        end else if (tick_wrap) begin
            tick_q <= '0;
            ms_q   <= ms_q + SPD_W'(1);
        end else begin
            tick_q <= tick_q + TICK_W'(1);
        end
    end

    // register port decode
    wire [ADDR_W-1:0] addr;
    wire [ADDR_W-1:0] preset_ofs;
    wire              wr;
    wire              rd;
    wire              preset_range;
    wire [2:0]        preset_rd_idx;

    assign addr          = reg_req_in.addr;
    assign wr            = reg_req_in.wr;
    assign rd            = reg_req_in.rd;
    assign preset_ofs    = addr - OFF_PRESET;
    assign preset_range  = (addr >= OFF_PRESET) && (addr[1:0] == 2'h0) &&
                           (preset_ofs < ADDR_W'(4 * NUM_PRESETS));
    assign preset_rd_idx = preset_ofs[4:2];

    wire wr_jog = wr && (addr == OFF_JOG_DECEL);
    wire wr_fwi = wr && (addr == OFF_FWD_INT);
    wire wr_rvi = wr && (addr == OFF_REV_INT);
    wire wr_fwe = wr && (addr == OFF_FWD_EXT);
    wire wr_rve = wr && (addr == OFF_REV_EXT);
    wire wr_max = wr && (addr == OFF_MAX_TQ);

    logic [TQ_W-1:0] fwd_int_q;
    logic [TQ_W-1:0] rev_int_q;
    logic [TQ_W-1:0] fwd_ext_q;
    logic [TQ_W-1:0] rev_ext_q;
    logic [TQ_W-1:0] max_tq_q;
    logic [SPD_W-1:0] preset_q [NUM_PRESETS];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            jog_decel_q <= JOG_DECEL_RST;
            fwd_int_q   <= FWD_INT_RST;
            rev_int_q   <= REV_INT_RST;
            fwd_ext_q   <= FWD_EXT_RST;
            rev_ext_q   <= REV_EXT_RST;
            max_tq_q    <= MAX_TQ_RST;
        end else begin
            if (wr_jog) jog_decel_q <= reg_req_in.wdata[SPD_W-1:0];
            if (wr_fwi) fwd_int_q   <= reg_req_in.wdata[TQ_W-1:0];
            if (wr_rvi) rev_int_q   <= reg_req_in.wdata[TQ_W-1:0];
            if (wr_fwe) fwd_ext_q   <= reg_req_in.wdata[TQ_W-1:0];
            if (wr_rve) rev_ext_q   <= reg_req_in.wdata[TQ_W-1:0];
            if (wr_max) max_tq_q    <= reg_req_in.wdata[TQ_W-1:0];
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PRESETS; p++) begin : g_preset
            wire hit = wr && (addr == OFF_PRESET + ADDR_W'(4 * p));
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    preset_q[p] <= PRESET_RST;
                end else if (hit) begin
                    preset_q[p] <= reg_req_in.wdata[SPD_W-1:0];
                end
            end
        end
    endgenerate

    // result flops; speed target is zero while stopping
    wire [2:0]       spd_idx;
    wire [SPD_W-1:0] spd_d;
    wire [POS_W-1:0] target_d;

    assign spd_idx  = applied_d.preset - 3'h1;
    assign spd_d    = (applied_d.mode == MODE_PRESET &&
                       state_d == ST_RUN) ? preset_q[spd_idx] : '0;
    assign target_d = contact_positioning_in ?
                      contact_target_in : commanded_pos_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_sel_out                <= '0;
            preset_speed_out            <= '0;
            decel_active_out            <= 1'b0;
            combo_error_out             <= 1'b0;
            target_position_monitor_out <= '0;
        end else begin
            mode_sel_out                <= applied_d;
            preset_speed_out            <= spd_d;
            decel_active_out            <= (state_d == ST_DECEL);
            combo_error_out             <= started_q && !code_legal;
            target_position_monitor_out <= target_d;
        end
    end

    torque_clamp u_fwd (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ext_en_in (host_s.forward_ext_limit),
        .int_lim_in(fwd_int_q),
        .ext_lim_in(fwd_ext_q),
        .max_lim_in(max_tq_q),
        .lim_out   (fwd_torque_limit_out)
    );

    torque_clamp u_rev (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ext_en_in (host_s.reverse_ext_limit),
        .int_lim_in(rev_int_q),
        .ext_lim_in(rev_ext_q),
        .max_lim_in(max_tq_q),
        .lim_out   (rev_torque_limit_out)
    );

    // read path
    wire [DATA_W-1:0] status_w;
    wire [DATA_W-1:0] rd_mux;

    assign status_w = (DATA_W'(code_q) << STAT_CODE_LSB) |
                      (DATA_W'(combo_error_out) << STAT_ERR_BIT) |
                      (DATA_W'(decel_active_out) << STAT_DECEL_BIT) |
                      (DATA_W'(mode_sel_out) << STAT_SEL_LSB);

    assign rd_mux =
        (addr == OFF_COMBO)     ? DATA_W'(code_q) :
        (addr == OFF_JOG_DECEL) ? DATA_W'(jog_decel_q) :
        (addr == OFF_FWD_INT)   ? DATA_W'(fwd_int_q) :
        (addr == OFF_REV_INT)   ? DATA_W'(rev_int_q) :
        (addr == OFF_FWD_EXT)   ? DATA_W'(fwd_ext_q) :
        (addr == OFF_REV_EXT)   ? DATA_W'(rev_ext_q) :
        (addr == OFF_MAX_TQ)    ? DATA_W'(max_tq_q) :
        (addr == OFF_STATUS)    ? status_w :
        (addr == OFF_TARGET)    ? DATA_W'(target_position_monitor_out) :
        preset_range            ? DATA_W'(preset_q[preset_rd_idx]) :
        '0;

    // data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= rd ? rd_mux : '0;
        end
    end

endmodule

// [rtl/mode_pkg.sv]
// constants, types and register map of the mode and torque limit selector
// assumes one 125 MHz clock, host inputs brought onto that clock by input_sync
// Function
// - Codes 4 to b name a mode pair, changed only by restart.
// - Codes 4 to 6 with all selects off run speed, position or torque.
// - Codes 4 to 6 otherwise run a preset, reverse while switched.
// - A preset select change is seen within two milliseconds.
// - Preset speed to pulse position first stops over jog time.
// - Codes 7 to 9 pick speed, torque or speed on, else the other.
// - Code a adds the zero clamp to analog speed while switched.
// - Code b blocks reference pulses in position while switched.
// - The applied torque limit never exceeds the motor maximum.
// - Internal limits are per direction, 400 wide, default 300.
// - The forward input picks forward external, else internal.
// - The reverse input picks reverse external, else internal.
// - External limits span 0 to 400, default 100, and act at once.
// - Outside contact operation the monitor shows commanded position.
// - During contact operation the monitor shows the contact target.
package mode_pkg;

    localparam int CLK_MHZ         = 125;
    localparam int CLK_PERIOD_NS   = 8;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TQ_W   = 9;
    localparam int SPD_W  = 16;
    localparam int POS_W  = 32;
    localparam int CODE_W = 4;
    localparam int NUM_PRESETS = 7;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_COMBO     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_JOG_DECEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FWD_INT   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_REV_INT   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FWD_EXT   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_REV_EXT   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_MAX_TQ    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_TARGET    = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_PRESET    = 8'h40;
    localparam logic [ADDR_W-1:0] PRESET_STRIDE = 8'h04;

    // status word fields
    localparam int STAT_SEL_LSB   = 0;
    localparam int STAT_DECEL_BIT = 9;
    localparam int STAT_ERR_BIT   = 10;
    localparam int STAT_CODE_LSB  = 12;

    // values after reset
    localparam logic [TQ_W-1:0]   FWD_INT_RST   = 9'h12c;
    localparam logic [TQ_W-1:0]   REV_INT_RST   = 9'h12c;
    localparam logic [TQ_W-1:0]   FWD_EXT_RST   = 9'h064;
    localparam logic [TQ_W-1:0]   REV_EXT_RST   = 9'h064;
    localparam logic [TQ_W-1:0]   MAX_TQ_RST    = 9'h190;
    localparam logic [SPD_W-1:0]  JOG_DECEL_RST = 16'h0064;
    localparam logic [SPD_W-1:0]  PRESET_RST    = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RST      = 4'h0;

    // combination codes
    localparam logic [CODE_W-1:0] CODE_PSPD_ASPD = 4'h4;
    localparam logic [CODE_W-1:0] CODE_PSPD_POS  = 4'h5;
    localparam logic [CODE_W-1:0] CODE_PSPD_TRQ  = 4'h6;
    localparam logic [CODE_W-1:0] CODE_POS_ASPD  = 4'h7;
    localparam logic [CODE_W-1:0] CODE_POS_TRQ   = 4'h8;
    localparam logic [CODE_W-1:0] CODE_TRQ_ASPD  = 4'h9;
    localparam logic [CODE_W-1:0] CODE_ASPD_ZCL  = 4'ha;
    localparam logic [CODE_W-1:0] CODE_POS_INH   = 4'hb;

    // preset filter and 1 ms tick
    localparam int PRESET_FILTER_US     = 1000;
    localparam int PRESET_FILTER_CYCLES = PRESET_FILTER_US * CLK_MHZ;
    localparam int MS_US                = 1000;
    localparam int MS_CYCLES            = MS_US * CLK_MHZ;

    typedef enum logic [2:0] {
        MODE_NONE,
        MODE_SPEED,
        MODE_POSITION,
        MODE_TORQUE,
        MODE_PRESET
    } ctrl_mode_t;

    typedef enum logic {
        ST_RUN,
        ST_DECEL
    } decel_state_t;

    typedef struct packed {
        ctrl_mode_t mode;
        logic       zero_clamp;
        logic       pulse_inhibit;
        logic       reverse;
        logic [2:0] preset;
    } mode_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // raw host levels, active low on the pins
    typedef struct packed {
        logic mode_switch;
        logic preset_select_a;
        logic reverse_ext_limit;
        logic forward_ext_limit;
    } host_inputs_t;

endpackage

// [rtl/input_sync.sv]
// two-stage synchroniser for active-low host inputs, active-high out
// assumes inputs idle high while the host is not driving them
`timescale 1ns/100ps
module input_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // pins and result
    input  wire logic [W-1:0] raw_n_in,
    output logic      [W-1:0] sync_out
);
    import mode_pkg::*;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q;
            logic stage_q;
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_q  <= 1'b1;
                    stage_q <= 1'b1;
                end else begin
                    meta_q  <= raw_n_in[g];
                    stage_q <= meta_q;
                end
            end
            // only the second stage is looked at
            assign sync_out[g] = ~stage_q;
        end
    endgenerate

endmodule

// [rtl/torque_clamp.sv]
// one direction of torque limit: internal/external pick, then clamp
// assumes limit values may change on any clock
`timescale 1ns/100ps
module torque_clamp (
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    // selection
    input  wire logic                      ext_en_in,
    input  wire logic [mode_pkg::TQ_W-1:0] int_lim_in,
    input  wire logic [mode_pkg::TQ_W-1:0] ext_lim_in,
    input  wire logic [mode_pkg::TQ_W-1:0] max_lim_in,
    // applied limit
    output logic      [mode_pkg::TQ_W-1:0] lim_out
);
    import mode_pkg::*;

    wire [TQ_W-1:0] picked;
    wire [TQ_W-1:0] clamped;

    assign picked  = ext_en_in ? ext_lim_in : int_lim_in;
    assign clamped = (picked > max_lim_in) ? max_lim_in : picked;

    // no restart needed: new values reach the output next edge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lim_out <= '0;
        end else begin
            lim_out <= clamped;
        end
    end

endmodule

// [sim/host_model.sv]
// partner model: host controller driving the discrete control inputs
// assumes the bench hands it active-high wishes, changed after clk_in edges
`timescale 1ns/100ps
module host_model (
    // wishes: mode switch, preset a, reverse ext, forward ext
    input  wire logic [3:0]         act_in,
    // pins, active low
    output mode_pkg::host_inputs_t  host_n_out
);
    import mode_pkg::*;
    assign host_n_out = ~act_in;
endmodule

// [sim/mode_checker_checker.sv]
// concurrent checks on the ports of the mode and torque limit selector
// assumes it is bound into servo_mode_and_torque_limit_select
`timescale 1ns/100ps
module mode_checker (
    // clock and reset
    input wire logic                        clk_in,
    input wire logic                        rst_in,
    // ports watched
    input wire mode_pkg::reg_req_t          reg_req_in,
    input wire logic [mode_pkg::DATA_W-1:0] rd_data_out,
    input wire logic                        contact_positioning_in,
    input wire logic [mode_pkg::POS_W-1:0]  commanded_pos_in,
    input wire logic [mode_pkg::POS_W-1:0]  contact_target_in,
    input wire mode_pkg::mode_sel_t         mode_sel_out,
    input wire logic [mode_pkg::SPD_W-1:0]  preset_speed_out,
    input wire logic                        decel_active_out,
    input wire logic                        combo_error_out,
    input wire logic [mode_pkg::TQ_W-1:0]   fwd_torque_limit_out,
    input wire logic [mode_pkg::TQ_W-1:0]   rev_torque_limit_out,
    input wire logic [mode_pkg::POS_W-1:0]  target_position_monitor_out
);
    import mode_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_contact;
        contact_positioning_in;
    endsequence
    sequence s_no_contact;
        !contact_positioning_in;
    endsequence
    property p_rd_idle;
        !$past(reg_req_in.rd) |-> rd_data_out == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data off slot");
    property p_clamp;
        fwd_torque_limit_out <= 9'h190 && rev_torque_limit_out <= 9'h190;
    endproperty
    a_clamp: assert property (p_clamp) else $error("limit above max");
    property p_mon_cmd;
        s_no_contact |=> target_position_monitor_out == $past(commanded_pos_in);
    endproperty
    a_mon_cmd: assert property (p_mon_cmd) else $error("monitor cmd");
    property p_mon_tgt;
        s_contact |=> target_position_monitor_out == $past(contact_target_in);
    endproperty
    a_mon_tgt: assert property (p_mon_tgt) else $error("monitor tgt");
    property p_zc;
        mode_sel_out.zero_clamp |-> mode_sel_out.mode == MODE_SPEED;
    endproperty
    a_zc: assert property (p_zc) else $error("clamp outside speed");
    property p_pi;
        mode_sel_out.pulse_inhibit |-> mode_sel_out.mode == MODE_POSITION;
    endproperty
    a_pi: assert property (p_pi) else $error("inhibit outside pos");
    property p_preset_only;
        mode_sel_out.mode != MODE_PRESET |->
            mode_sel_out.preset == 3'h0 && !mode_sel_out.reverse
            && preset_speed_out == '0;
    endproperty
    a_preset_only: assert property (p_preset_only)
        else $error("stray preset");
    property p_rev;
        mode_sel_out.reverse |-> mode_sel_out.preset >= 3'h4;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse low preset");
    property p_decel;
        decel_active_out |->
            preset_speed_out == '0 && mode_sel_out.mode == MODE_PRESET;
    endproperty
    a_decel: assert property (p_decel) else $error("decel state");
    property p_err;
        combo_error_out |-> mode_sel_out.mode == MODE_NONE ##1 combo_error_out;
    endproperty
    a_err: assert property (p_err) else $error("bad code state");
endmodule

// [sim/testbench.sv]
// self-checking bench of the mode and torque limit selector
// assumes the host model on the pins and a plain register port
`timescale 1ns/100ps
module testbench;
    import mode_pkg::*;
    logic         clk_in, rst_in, contact, decel, cerr;
    reg_req_t     req;
    logic [31:0]  rdat, d, cmd_pos, tgt_pos, mon;
    logic [3:0]   code, act;
    host_inputs_t host_n;
    mode_sel_t    msel;
    logic [15:0]  spd;
    logic [8:0]   fwd_lim, rev_lim;
    int           err_total, tests_run, n;
    host_model host_model_i (.act_in(act), .host_n_out(host_n));
    servo_mode_and_torque_limit_select #(.PRESET_FILTER(4), .MS_TICK(4))
    servo_mode_and_torque_limit_select_i (
        .clk_in, .rst_in, .reg_req_in(req),
        .rd_data_out(rdat), .control_combo_code_in(code), .host_n_in(host_n),
        .contact_positioning_in(contact), .commanded_pos_in(cmd_pos),
        .contact_target_in(tgt_pos), .mode_sel_out(msel),
        .preset_speed_out(spd), .decel_active_out(decel),
        .combo_error_out(cerr), .fwd_torque_limit_out(fwd_lim),
        .rev_torque_limit_out(rev_lim), .target_position_monitor_out(mon));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task close_out;
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in) req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_in) req <= '0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_in) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_in) req <= '0;
        #1 d = rdat;
    endtask
    task rst_code(input logic [3:0] c);
        rst_in <= 1'b1;
        code <= c;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask
    task settle;
        repeat (12) @(posedge clk_in);
        #1;
    endtask
    function automatic logic [8:0] em(input logic [3:0] c, input logic m);
        ctrl_mode_t md;
        case (c)
            4'h4, 4'ha: md = MODE_SPEED;
            4'h6: md = MODE_TORQUE;
            4'h7: md = m ? MODE_SPEED : MODE_POSITION;
            4'h8: md = m ? MODE_TORQUE : MODE_POSITION;
            4'h9: md = m ? MODE_SPEED : MODE_TORQUE;
            4'h5, 4'hb: md = MODE_POSITION;
            default: md = MODE_NONE;
        endcase
        return {md, m && c == 4'ha, m && c == 4'hb, 4'h0};
    endfunction
    task t_regs;
        logic [7:0] o [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h04, 8'h30};
        logic [8:0] v [7] = '{9'h12c, 9'h12c, 9'h064, 9'h064, 9'h190,
                              9'h064, 9'h000};
        rst_code(4'h5);
        for (int i = 0; i < 7; i++) begin
            rd(o[i]);
            chk("reg_reset", 32'(v[i]), d);
        end
        wr(OFF_COMBO, 32'h9);
        code <= 4'h7;
        rd(OFF_STATUS);
        chk("code_held", 32'h5, 32'(d[15:12]));
    endtask
    task t_modes;
        for (int c = 4; c < 13; c++) begin
            for (int m = 0; m < 2; m++) begin
                if ((c < 7 || c == 12) && m == 1) continue;
                rst_code(4'(c));
                act <= {m[0], 3'h0};
                settle();
                d = 32'(em(4'(c), m[0]));
                chk("mode", d, 32'(msel));
                chk("code_err", 32'(c == 12), 32'(cerr));
            end
        end
    endtask
    task t_torque;
        rst_code(4'h8);
        act <= 4'h0;
        settle();
        chk("fwd_int", 32'h12c, 32'(fwd_lim));
        act <= 4'h1;
        settle();
        chk("fwd_ext", 32'h064, 32'(fwd_lim));
        chk("rev_int", 32'h12c, 32'(rev_lim));
        act <= 4'h3;
        settle();
        chk("rev_ext", 32'h064, 32'(rev_lim));
        wr(OFF_FWD_EXT, 32'h150);
        repeat (2) @(posedge clk_in);
        #1 chk("fwd_new", 32'h150, 32'(fwd_lim));
        wr(OFF_MAX_TQ, 32'h0c8);
        repeat (2) @(posedge clk_in);
        #1 chk("fwd_clamp", 32'h0c8, 32'(fwd_lim));
        chk("rev_below", 32'h064, 32'(rev_lim));
    endtask
    task t_preset_decel;
        rst_code(4'h5);
        act <= 4'h0;
        for (int i = 0; i < 7; i++) wr(OFF_PRESET + 8'(4 * i), 32'h100 + i + 1);
        wr(OFF_JOG_DECEL, 32'h2);
        for (int k = 1; k < 8; k++) begin
            act <= {k[2:0], 1'b0};
            settle();
            d = 32'({MODE_PRESET, 2'b00, k[2], k[2:0]});
            chk("preset", d, 32'(msel));
            chk("preset_speed", 32'h100 + k, 32'(spd));
        end
        act <= 4'h0;
        n = 0;
        while (decel !== 1'b1 && n < 20) #CLK_PERIOD_NS n++;
        chk("decel_start", 32'h1, 32'(decel));
        n = 0;
        while (decel !== 1'b0 && n < 100) #CLK_PERIOD_NS n++;
        chk("decel_long", 32'h1, 32'(n >= 8 && n < 100));
        settle();
        chk("after_decel", 32'(em(4'h5, 1'b0)), 32'(msel));
    endtask
    task t_monitor;
        cmd_pos <= 32'h1234_5678;
        tgt_pos <= 32'h0bad_f00d;
        contact <= 1'b0;
        settle();
        chk("mon_cmd", 32'h1234_5678, mon);
        contact <= 1'b1;
        settle();
        chk("mon_tgt", 32'h0bad_f00d, mon);
    endtask
    initial begin
        rst_in = 1'b1;
        req = '0;
        code = 4'h5;
        act = 4'h0;
        contact = 1'b0;
        cmd_pos = '0;
        tgt_pos = '0;
        err_total = 0;
        tests_run = 0;
        t_regs();
        t_modes();
        t_torque();
        t_preset_decel();
        t_monitor();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        err_total++;
        close_out();
    end
endmodule
bind servo_mode_and_torque_limit_select mode_checker mode_checker_i (.*);
